// File: common/dmcio_regs.vh
/*
  opcode patterns, field positions and cycle counts for the multiply,
  control and i/o instruction decoder. assumes 16-bit instruction words.
*/
`ifndef DMCIO_REGS_VH
`define DMCIO_REGS_VH

// single-word opcodes, full 16 bits
`define DMCIO_OP_ADD_PRODUCT 16'h7f8f
`define DMCIO_OP_PRODUCT_TO_ACC 16'h7f8e
`define DMCIO_OP_SUBTRACT_PRODUCT 16'h7f90
`define DMCIO_OP_IRQ_MASK 16'h7f81
`define DMCIO_OP_IRQ_UNMASK 16'h7f82
`define DMCIO_OP_SATURATION_OFF 16'h7f8a
`define DMCIO_OP_SATURATION_ON 16'h7f8b
`define DMCIO_OP_POP 16'h7f9d
`define DMCIO_OP_PUSH 16'h7f9c
`define DMCIO_OP_NOP 16'h7f80

// upper-byte opcodes, bits 15:8
`define DMCIO_HI_LOAD_FACTOR 8'h6a
`define DMCIO_HI_LOAD_FACTOR_ADD 8'h6c
`define DMCIO_HI_LOAD_FACTOR_ADD_SHIFT 8'h6b
`define DMCIO_HI_MULTIPLY 8'h6d
`define DMCIO_HI_DATA_SHIFT 8'h69
`define DMCIO_HI_TABLE_READ 8'h67
`define DMCIO_HI_TABLE_WRITE 8'h7d
`define DMCIO_HI_STATUS_LOAD 8'h7b
`define DMCIO_HI_STATUS_SAVE 8'h7c

// bits 15:11 for port transfers, bits 15:13 for multiply immediate
`define DMCIO_PORT_READ_TOP 5'h08
`define DMCIO_PORT_WRITE_TOP 5'h09
`define DMCIO_MPY_IMM_TOP 3'h4

// fields
`define DMCIO_PORT_MSB 10
`define DMCIO_PORT_LSB 8
`define DMCIO_ADDR_MSB 6
`define DMCIO_IMM_MSB 12

// machine cycles per instruction
`define DMCIO_CYC_ONE 2'h1
`define DMCIO_CYC_TWO 2'h2
`define DMCIO_CYC_THREE 2'h3

// status bits after reset
`define DMCIO_IRQ_MASK_RESET 1'b1
`define DMCIO_SAT_RESET 1'b0

`endif

// File: hw/dmcio_decode.v
/*
  decoder and executor for product-register, stack, control, port and
  table instructions of a 16-bit fixed-point processor.
  assumes data and program memory answer combinationally within a cycle;
  instr_valid_i is honoured only while busy_o is low.
*/
// How it works
// - add-product adds product register to accumulator, one word, one cycle.
// - load-factor-and-add loads factor register and adds product, one cycle.
// - load-factor-add-shift also copies addressed word to next address, one cycle.
// - multiply puts factor times data word into product register, one cycle.
// - top bits 100 select multiply by the 13-bit immediate, one cycle.
// - product-to-accumulator loads accumulator from product, one cycle.
// - subtract-product subtracts product from accumulator, one cycle.
// - pop moves stack top into accumulator in two cycles.
// - push places accumulator onto stack in two cycles.
// - data-shift copies addressed word to next higher address, one cycle.
// - port read moves selected port word into data memory, two cycles.
// - table read copies program word at accumulator into data memory, three cycles.
// - table write copies data word into program memory, three cycles.
`timescale 1ns/1ps
`include "dmcio_regs.vh"

module dmcio_decode #(
  parameter STACK_DEPTH = 4,
  parameter PTR_W = 2
) (
  input wire clk_i,
  input wire reset_i,
  input wire instr_valid_i,
  input wire [15:0] instr_i,
  input wire [7:0] data_page_i,
  input wire [15:0] dmem_rdata_i,
  input wire [15:0] pmem_rdata_i,
  input wire [15:0] port_rdata_i,
  output wire busy_o,
  output reg done_o,
  output wire [7:0] dmem_addr_o,
  output reg dmem_we_o,
  output reg [7:0] dmem_waddr_o,
  output reg [15:0] dmem_wdata_o,
  output wire [11:0] pmem_addr_o,
  output reg pmem_we_o,
  output reg [15:0] pmem_wdata_o,
  output reg [2:0] port_number_field_o,
  output reg port_rd_o,
  output reg port_wr_o,
  output reg [15:0] port_wdata_o,
  output reg [31:0] acc_o,
  output reg [31:0] product_o,
  output reg [15:0] factor_o,
  output reg irq_masked_o,
  output reg saturate_o,
  output reg stack_overflow_o
);

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;

  reg [1:0] state;
  reg [1:0] cyc_left;
  reg [15:0] held;
  reg [PTR_W:0] sp;

  wire go = instr_valid_i && (state == ST_IDLE);
  wire [15:0] ir = go ? instr_i : held;
  wire [7:0] hi = ir[15:8];
  wire [7:0] daddr = {data_page_i[0], ir[`DMCIO_ADDR_MSB:0]};

  wire is_add_product_op = (ir == `DMCIO_OP_ADD_PRODUCT);
  wire is_pac = (ir == `DMCIO_OP_PRODUCT_TO_ACC);
  wire is_subtract_product_op = (ir == `DMCIO_OP_SUBTRACT_PRODUCT);
  wire is_pop = (ir == `DMCIO_OP_POP);
  wire is_push = (ir == `DMCIO_OP_PUSH);
  wire is_lt = (hi == `DMCIO_HI_LOAD_FACTOR);
  wire is_lta = (hi == `DMCIO_HI_LOAD_FACTOR_ADD);
  wire is_ltd = (hi == `DMCIO_HI_LOAD_FACTOR_ADD_SHIFT);
  wire is_mpy = (hi == `DMCIO_HI_MULTIPLY);
  wire is_data_shift_op = (hi == `DMCIO_HI_DATA_SHIFT);
  wire is_table_read_op = (hi == `DMCIO_HI_TABLE_READ);
  wire is_table_write_op = (hi == `DMCIO_HI_TABLE_WRITE);
  wire is_multiply_immediate_op = (ir[15:13] == `DMCIO_MPY_IMM_TOP);
  wire is_in = (ir[15:11] == `DMCIO_PORT_READ_TOP);
  wire is_out = (ir[15:11] == `DMCIO_PORT_WRITE_TOP);

  // cycle count of the incoming instruction
  reg [1:0] cycles;
  always @*
  begin
    cycles = `DMCIO_CYC_ONE;
    if (is_table_read_op || is_table_write_op)
      cycles = `DMCIO_CYC_THREE;
    else if (is_pop || is_push || is_in || is_out)
      cycles = `DMCIO_CYC_TWO;
  end

  assign busy_o = (state != ST_IDLE);
  assign dmem_addr_o = daddr;
  // table address comes from the low accumulator bits
  assign pmem_addr_o = acc_o[11:0];

  // signed 16x16 product, signed immediate sign-extended
  wire [15:0] mult_b = is_multiply_immediate_op ? {{3{ir[`DMCIO_IMM_MSB]}}, ir[`DMCIO_IMM_MSB:0]} : dmem_rdata_i;
  wire [31:0] mult = $signed(factor_o) * $signed(mult_b);

  // overflow handling only matters for add and subtract
  wire [32:0] sum = {acc_o[31], acc_o} + {product_o[31], product_o};
  wire [32:0] dif = {acc_o[31], acc_o} - {product_o[31], product_o};
  wire [32:0] arith = is_subtract_product_op ? dif : sum;
  wire ovf = arith[32] ^ arith[31];
  wire [31:0] arith_sat = arith[32] ? 32'h80000000 : 32'h7fffffff;
  wire [31:0] arith_res = (ovf && saturate_o) ? arith_sat : arith[31:0];

  // last cycle of the running instruction performs the work
  wire fire = (go && cycles == `DMCIO_CYC_ONE) || (state == ST_WAIT && cyc_left == `DMCIO_CYC_ONE);
  wire stack_empty = (sp == {(PTR_W+1){1'b0}});
  wire stack_full = (sp == STACK_DEPTH[PTR_W:0]);
  wire [PTR_W:0] sp_dec = sp - {{PTR_W{1'b0}}, 1'b1};

  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state <= ST_IDLE;
      cyc_left <= 2'h0;
      held <= 16'h0000;
    end
    else if (go && cycles != `DMCIO_CYC_ONE)
    begin
      state <= ST_WAIT;
      cyc_left <= cycles - `DMCIO_CYC_ONE;
      held <= instr_i;
    end
    else if (state == ST_WAIT)
    begin
      cyc_left <= cyc_left - `DMCIO_CYC_ONE;
      if (cyc_left == `DMCIO_CYC_ONE)
        state <= ST_IDLE;
    end
  end

  wire [32*STACK_DEPTH-1:0] stack_bus;
  wire [PTR_W-1:0] push_idx = sp[PTR_W-1:0];
  wire [PTR_W-1:0] pop_idx = sp_dec[PTR_W-1:0];
  wire push_ok = fire && is_push && !stack_full;
  wire pop_ok = fire && is_pop && !stack_empty;
  // an empty pop yields zero rather than stale stack contents
  wire [31:0] pop_word = stack_empty ? 32'h00000000 : stack_bus[pop_idx*32 +: 32];
  // memory writes happen on the final cycle only
  wire shift_wr = fire && (is_ltd || is_data_shift_op);
  wire load_wr = fire && (is_in || is_table_read_op);

  // completion pulse and port strobes
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      done_o <= 1'b0;
      port_rd_o <= 1'b0;
      port_wr_o <= 1'b0;
      port_number_field_o <= 3'h0;
    end
    else
    begin
      done_o <= fire;
      // port strobes on the second cycle of a two-cycle port access
      port_rd_o <= go && is_in;
      port_wr_o <= go && is_out;
      if (go && (is_in || is_out))
        port_number_field_o <= ir[`DMCIO_PORT_MSB:`DMCIO_PORT_LSB];
    end
  end

  // accumulator: sums, product load and stack pop
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      acc_o <= 32'h00000000;
    else if (fire)
    begin
      if (is_add_product_op || is_lta || is_ltd || is_subtract_product_op)
        acc_o <= arith_res;
      else if (is_pac)
        acc_o <= product_o;
      else if (is_pop)
        acc_o <= pop_word;
    end
  end

  // factor and product registers
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      factor_o <= 16'h0000;
      product_o <= 32'h00000000;
    end
    else if (fire)
    begin
      if (is_lt || is_lta || is_ltd)
        factor_o <= dmem_rdata_i;
      if (is_mpy || is_multiply_immediate_op)
        product_o <= mult;
    end
  end

  // data memory write port
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      dmem_we_o <= 1'b0;
      dmem_waddr_o <= 8'h00;
      dmem_wdata_o <= 16'h0000;
    end
    else
    begin
      dmem_we_o <= shift_wr || load_wr;
      // the shift target wraps at the top of the 8-bit window
      if (shift_wr)
      begin
        dmem_waddr_o <= daddr + 8'h01;
        dmem_wdata_o <= dmem_rdata_i;
      end
      else if (load_wr)
      begin
        dmem_waddr_o <= daddr;
        dmem_wdata_o <= is_in ? port_rdata_i : pmem_rdata_i;
      end
    end
  end

  // program memory and port write data
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      pmem_we_o <= 1'b0;
      pmem_wdata_o <= 16'h0000;
      port_wdata_o <= 16'h0000;
    end
    else
    begin
      pmem_we_o <= fire && is_table_write_op;
      if (fire && is_table_write_op)
        pmem_wdata_o <= dmem_rdata_i;
      if (fire && is_out)
        port_wdata_o <= dmem_rdata_i;
    end
  end

  // status bits; status load and save act as no-ops
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      irq_masked_o <= `DMCIO_IRQ_MASK_RESET;
      saturate_o <= `DMCIO_SAT_RESET;
    end
    else if (fire)
    begin
      if (ir == `DMCIO_OP_IRQ_MASK)
        irq_masked_o <= 1'b1;
      else if (ir == `DMCIO_OP_IRQ_UNMASK)
        irq_masked_o <= 1'b0;
      if (ir == `DMCIO_OP_SATURATION_ON)
        saturate_o <= 1'b1;
      else if (ir == `DMCIO_OP_SATURATION_OFF)
        saturate_o <= 1'b0;
    end
  end

  // full push drops the word; the flag is sticky until reset
  always @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      sp <= {(PTR_W+1){1'b0}};
      stack_overflow_o <= 1'b0;
    end
    else
    begin
      if (push_ok)
        sp <= sp + {{PTR_W{1'b0}}, 1'b1};
      else if (pop_ok)
        sp <= sp_dec;
      if (fire && is_push && stack_full)
        stack_overflow_o <= 1'b1;
    end
  end

  // one flip-flop word per stack entry
  genvar g;
  generate
    for (g = 0; g < STACK_DEPTH; g = g + 1)
    begin : g_stack
      reg [31:0] word;
      always @(posedge clk_i or posedge reset_i)
      begin
        if (reset_i)
          word <= 32'h00000000;
        else if (push_ok && push_idx == g)
          word <= acc_o;
      end
      assign stack_bus[g*32 +: 32] = word;
    end
  endgenerate

endmodule

// File: dv/dmcio_decode_asserts.sv
/* port assertions for dmcio_decode.
   assumes one clock and reset_i active high. */
`timescale 1ns/1ps
`include "dmcio_regs.vh"
module dmcio_decode_asserts (
  input wire clk_i,
  input wire reset_i,
  input wire instr_valid_i,
  input wire [15:0] instr_i,
  input wire [15:0] dmem_rdata_i,
  input wire busy_o,
  input wire done_o,
  input wire dmem_we_o,
  input wire port_rd_o,
  input wire [31:0] acc_o,
  input wire [31:0] product_o,
  input wire [15:0] factor_o,
  input wire irq_masked_o,
  input wire saturate_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  wire tk = instr_valid_i & ~busy_o;
  // saturation would clip, so sums are only exact with it off
  wire add_ok = tk & ~saturate_o;
  wire [12:0] imm = instr_i[12:0];
  wire is_mask = instr_i == `DMCIO_OP_IRQ_MASK;
  wire is_sat = instr_i == `DMCIO_OP_SATURATION_ON;
  property p_add_product_op;
    add_ok && instr_i == `DMCIO_OP_ADD_PRODUCT |=> done_o && acc_o == $past(acc_o) + $past(product_o);
  endproperty
  a_add_product_op: assert property (p_add_product_op) else $error("add product wrong");
  property p_pac;
    tk && instr_i == `DMCIO_OP_PRODUCT_TO_ACC |=> done_o && acc_o == $past(product_o);
  endproperty
  a_pac: assert property (p_pac) else $error("product to acc wrong");
  property p_subtract_product_op;
    add_ok && instr_i == `DMCIO_OP_SUBTRACT_PRODUCT |=> acc_o == $past(acc_o) - $past(product_o);
  endproperty
  a_subtract_product_op: assert property (p_subtract_product_op) else $error("subtract product wrong");
  property p_mpy;
    tk && instr_i[15:8] == `DMCIO_HI_MULTIPLY |=> $signed(product_o) == $signed($past(factor_o)) * $signed($past(dmem_rdata_i));
  endproperty
  a_mpy: assert property (p_mpy) else $error("multiply wrong");
  property p_multiply_immediate_op;
    tk && instr_i[15:13] == `DMCIO_MPY_IMM_TOP |=> $signed(product_o) == $signed($past(factor_o)) * $signed($past(imm));
  endproperty
  a_multiply_immediate_op: assert property (p_multiply_immediate_op) else $error("multiply immediate wrong");
  property p_stack;
    tk && (instr_i == `DMCIO_OP_POP || instr_i == `DMCIO_OP_PUSH) |=> busy_o ##1 done_o && !busy_o;
  endproperty
  a_stack: assert property (p_stack) else $error("stack timing wrong");
  property p_table;
    tk && (instr_i[15:8] == `DMCIO_HI_TABLE_READ || instr_i[15:8] == `DMCIO_HI_TABLE_WRITE) |=> busy_o[*2] ##1 done_o;
  endproperty
  a_table: assert property (p_table) else $error("table timing wrong");
  property p_in;
    tk && instr_i[15:11] == `DMCIO_PORT_READ_TOP |=> port_rd_o && busy_o ##1 done_o && dmem_we_o;
  endproperty
  a_in: assert property (p_in) else $error("port read timing wrong");
  property p_irq;
    tk && (is_mask || instr_i == `DMCIO_OP_IRQ_UNMASK) |=> done_o && irq_masked_o == $past(is_mask);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mask wrong");
  property p_sat;
    tk && (is_sat || instr_i == `DMCIO_OP_SATURATION_OFF) |=> done_o && saturate_o == $past(is_sat);
  endproperty
  a_sat: assert property (p_sat) else $error("saturation wrong");
endmodule
bind dmcio_decode dmcio_decode_asserts chk_u (.clk_i, .reset_i, .instr_valid_i, .instr_i, .dmem_rdata_i, .busy_o,
  .done_o, .dmem_we_o, .port_rd_o, .acc_o, .product_o, .factor_o, .irq_masked_o, .saturate_o);

// File: dv/dmcio_decode_tb_top.sv
/* self-checking bench for dmcio_decode.
   assumes memories answer combinationally; modelled here. */
`timescale 1ns/1ps
`include "dmcio_regs.vh"
module dmcio_decode_tb_top;
  reg clk_i = 0;
  reg reset_i = 1;
  reg instr_valid_i = 0;
  reg [15:0] instr_i = 16'h0000;
  reg [15:0] port_rdata_i = 16'h0000;
  reg [7:0] data_page_i = 8'h00;
  reg [7:0] dhi = 8'h01;
  wire busy_o, done_o, dmem_we_o, pmem_we_o, port_rd_o, port_wr_o, irq_masked_o, saturate_o, stack_overflow_o;
  wire [7:0] dmem_addr_o, dmem_waddr_o;
  wire [11:0] pmem_addr_o;
  wire [15:0] dmem_wdata_o, pmem_wdata_o, port_wdata_o, factor_o;
  wire [2:0] port_number_field_o;
  wire [31:0] acc_o, product_o;
  // address folded into the word so every location reads distinct
  wire [15:0] dmem_rdata_i = {dhi, dmem_addr_o};
  wire [15:0] pmem_rdata_i = {4'ha, pmem_addr_o};
  reg [7:0] wa;
  reg [15:0] wd, pw, pd;
  reg [2:0] pn;
  integer n_mismatch = 0;
  integer num_checks = 0;
  dmcio_decode uut (.clk_i, .reset_i, .instr_valid_i, .instr_i, .data_page_i, .dmem_rdata_i, .pmem_rdata_i,
    .port_rdata_i, .busy_o, .done_o, .dmem_addr_o, .dmem_we_o, .dmem_waddr_o, .dmem_wdata_o, .pmem_addr_o,
    .pmem_we_o, .pmem_wdata_o, .port_number_field_o, .port_rd_o, .port_wr_o, .port_wdata_o, .acc_o, .product_o,
    .factor_o, .irq_masked_o, .saturate_o, .stack_overflow_o);
  always #12.5 clk_i = ~clk_i;
  // write pulses last one cycle, so latch them for later checks
  always @(posedge clk_i)
  begin
    if (dmem_we_o) {wa, wd} <= {dmem_waddr_o, dmem_wdata_o};
    if (pmem_we_o) pw <= pmem_wdata_o;
    if (port_rd_o | port_wr_o) pn <= port_number_field_o;
    if (done_o) pd <= port_wdata_o;
  end
  task results;
  begin
    if (n_mismatch == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
  begin
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED %0s expected %h seen %h", name, exp, got);
    end
  end
  endtask
  task run_op(input [15:0] op, input logic [31:0] cyc);
    integer k;
  begin
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= op;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    k = 1;
    #1;
    while (done_o !== 1'b1 && k < 10)
    begin
      @(posedge clk_i);
      #1;
      k = k + 1;
    end
    chk("cycles", cyc, k);
    if (k == 10) results;
    @(posedge clk_i);
    #1;
  end
  endtask
  task t_status;
  begin
    chk("irqmask", 1, irq_masked_o);
    chk("sat", 0, saturate_o);
    run_op(`DMCIO_OP_IRQ_UNMASK, 1);
    chk("irqmask", 0, irq_masked_o);
    run_op(`DMCIO_OP_IRQ_MASK, 1);
    chk("irqmask", 1, irq_masked_o);
    run_op(`DMCIO_OP_SATURATION_ON, 1);
    chk("sat", 1, saturate_o);
    run_op(`DMCIO_OP_SATURATION_OFF, 1);
    chk("sat", 0, saturate_o);
  end
  endtask
  task t_mult;
  begin
    run_op(16'h6a05, 1);
    chk("factor", 16'h0105, factor_o);
    run_op(16'h6d03, 1);
    chk("product", 32'h0001080f, product_o);
    run_op(`DMCIO_OP_PRODUCT_TO_ACC, 1);
    chk("acc", 32'h0001080f, acc_o);
    run_op(`DMCIO_OP_ADD_PRODUCT, 1);
    chk("acc", 32'h0002101e, acc_o);
    run_op(`DMCIO_OP_SUBTRACT_PRODUCT, 1);
    chk("acc", 32'h0001080f, acc_o);
    run_op(16'h9fff, 1);
    chk("product", 32'hfffffefb, product_o);
    run_op(16'h6c02, 1);
    chk("factor", 16'h0102, factor_o);
    chk("acc", 32'h0001070a, acc_o);
    run_op(16'h6b04, 1);
    chk("acc", 32'h00010605, acc_o);
    chk("waddr", 8'h05, wa);
    chk("wdata", 16'h0104, wd);
  end
  endtask
  task t_stack;
  begin
    run_op(`DMCIO_OP_PUSH, 2);
    run_op(`DMCIO_OP_PRODUCT_TO_ACC, 1);
    run_op(`DMCIO_OP_POP, 2);
    chk("acc", 32'h00010605, acc_o);
  end
  endtask
  task t_io;
  begin
    @(posedge clk_i);
    port_rdata_i <= 16'hbeef;
    run_op(16'h4510, 2);
    chk("waddr", 8'h10, wa);
    chk("wdata", 16'hbeef, wd);
    chk("port", 3'd5, pn);
    run_op(16'h4b20, 2);
    chk("pdata", 16'h0120, pd);
    chk("port", 3'd3, pn);
  end
  endtask
  task t_table;
  begin
    run_op(16'h6730, 3);
    chk("waddr", 8'h30, wa);
    chk("wdata", 16'ha605, wd);
    run_op(16'h7d31, 3);
    chk("pdata", 16'h0131, pw);
  end
  endtask
  task t_shift;
  begin
    @(posedge clk_i);
    data_page_i <= 8'h01;
    run_op(16'h697f, 1);
    chk("waddr", 8'h00, wa);
    chk("wdata", 16'h01ff, wd);
  end
  endtask
  // near-full operands so a second sum must clip
  task t_sat;
  begin
    @(posedge clk_i);
    dhi <= 8'h7f;
    run_op(16'h6a7f, 1);
    run_op(16'h6d7f, 1);
    chk("product", 32'h3fff0001, product_o);
    run_op(`DMCIO_OP_PRODUCT_TO_ACC, 1);
    run_op(`DMCIO_OP_SATURATION_ON, 1);
    run_op(`DMCIO_OP_ADD_PRODUCT, 1);
    chk("acc", 32'h7ffe0002, acc_o);
    run_op(`DMCIO_OP_ADD_PRODUCT, 1);
    chk("acc", 32'h7fffffff, acc_o);
    run_op(`DMCIO_OP_SATURATION_OFF, 1);
  end
  endtask
  task t_overflow;
    integer n;
  begin
    for (n = 0; n < 4; n = n + 1)
      run_op(`DMCIO_OP_PUSH, 2);
    chk("overflow", 0, stack_overflow_o);
    run_op(`DMCIO_OP_PUSH, 2);
    chk("overflow", 1, stack_overflow_o);
    run_op(`DMCIO_OP_PRODUCT_TO_ACC, 1);
    for (n = 0; n < 4; n = n + 1)
    begin
      run_op(`DMCIO_OP_POP, 2);
      chk("acc", 32'h7fffffff, acc_o);
    end
  end
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    t_status;
    t_mult;
    t_stack;
    t_io;
    t_table;
    t_shift;
    t_sat;
    t_overflow;
    results;
  end
endmodule
